// >>> alcs_cfg.svh
// Constants for the asynchronous line configuration and status block.
// Assumes a 40 MHz host clock and a 3-bit register index on the host port.
`ifndef ALCS_CFG_SVH
`define ALCS_CFG_SVH

// ----------------------------------------
// Register indices on the host port
// ----------------------------------------
`define ALCS_IDX_LINE_CONTROL 3'h0
`define ALCS_IDX_RX_EVENT 3'h1
`define ALCS_IDX_TX_STATUS 3'h2
`define ALCS_IDX_SYS_CONTROL 3'h3
`define ALCS_IDX_SEC_SELECT 3'h4
`define ALCS_IDX_SEC_ACCESS 3'h5

// ----------------------------------------
// Line control word fields
// ----------------------------------------
`define ALCS_LCW_SEL_LO 9
`define ALCS_LCW_DATA_LO 11
`define ALCS_LCW_STROBE 15
`define ALCS_SEL_PRIMARY 2'h0
`define ALCS_SEL_SPEED 2'h1
`define ALCS_SEL_FORMAT 2'h2
`define ALCS_SEL_LOOPBACK 2'h3
`define ALCS_PRI_RX_ENABLE 2
`define ALCS_LOOP_INTERNAL 0
`define ALCS_SPEED_38400 4'hf

// ----------------------------------------
// Secondary select fields and receive event codes
// ----------------------------------------
`define ALCS_SS_LINE_LO 0
`define ALCS_SS_REG_LO 8
`define ALCS_BCC_REG_CODE 4'hb
`define ALCS_RX_SPECIAL 4'h0
`define ALCS_RX_PARITY 4'h1
`define ALCS_RX_OVERRUN 4'h2
`define ALCS_RX_FRAMING 4'h3
`define ALCS_RX_COUNT_WARN 4'h4
`define ALCS_RX_BCC_DONE 4'h5
`define ALCS_RX_COUNT_ZERO 4'h8
`define ALCS_RX_NXM_STORE 4'hc
`define ALCS_RX_NXM_FETCH 4'hd
`define ALCS_RX_MPAR_STORE 4'he
`define ALCS_RX_MPAR_FETCH 4'hf

// ----------------------------------------
// Timing
// ----------------------------------------
`define ALCS_CLK_HZ 40000000
`define ALCS_OVERSAMPLE 16
`endif

// >>> alcs_pkg.sv
// Types shared by the asynchronous line configuration and status block.
// Assumes nothing beyond the constants header.
package alcs_pkg;
	typedef struct packed
	{
		logic valid;
		logic [7:0] char_data;
		logic [3:0] line;
		logic special;
		logic parity_err;
		logic overrun;
		logic framing;
		logic count_warn;
		logic count_zero;
		logic bcc_done;
		logic [15:0] bcc;
		logic nxm_store;
		logic nxm_fetch;
		logic mpar_store;
		logic mpar_fetch;
	} alcs_rx_evt_t;

	typedef struct packed
	{
		logic valid;
		logic [3:0] code;
		logic [3:0] line;
	} alcs_tx_evt_t;

	typedef struct packed
	{
		logic strobe;
		logic [1:0] sel;
		logic [3:0] data;
		logic [3:0] ss_line;
		logic [3:0] ss_reg;
		logic [15:0] receive_event_word;
		logic nsr_valid;
		logic irq;
		logic [6:0] wptr;
		logic [6:0] rptr;
		logic ready;
		logic [15:0] rdata;
		logic [15:0][3:0] speed;
		logic [15:0][3:0] primary;
		logic [15:0] loopback;
		logic [15:0] hold;
		logic [15:0] rx_to_card;
		logic [15:0] tx_line;
		logic [15:0] pause;
		logic [2:0][15:0] rx_sync;
		logic [2:0][15:0] stop_sync;
		logic [15:0] rx_pin_f;
		logic [15:0] stop_f;
		logic [15:0] divisor;
	} alcs_state_t;
endpackage

// >>> alcs_line_config_status.sv
// Host register bank for 16 asynchronous lines: line card setup, flow control
// pins, transmit status silo, secondary register access and receive event word.
// Assumes a host that issues one-cycle read and write strobes on sys_clk and a
// character processor that reports events as one-cycle structs.
//
// Overview of operation
// - Code 01 strobe loads selected line speed
// - Speed code sets both directions' rate
// - Code 11 strobe loads selected line maintenance
// - Loop bit loops tx to rx, blocks pins
// - Strobe copies data then clears itself; a code 10 strobe stores nothing here
// - Hold raised within 10/16 bit time
// - Hold off after reset, clear, rx disable
// - Hold used at 38400; far end restrains
// - Remote stop withholds the next character
// - Ignore remote stop in loop or slow
// - 64-entry silo queues transmit conditions
// - New entry sets valid and interrupt request
// - Status read pops, clears valid and request
// - Reset clears valid and request, keeps the word
// - Select holds line and register code
// - 16 lines with 16 secondary registers
// - Codes 0000, 0001, 0010 for receive events
// - Code 0011 means framing error here
// - Code 0100 on byte count reaching zero
// - Code 1000 when count already zero
// - Block check stored and byte OR reported
// - Codes 1100-1111 for memory faults
// - Event word holds character and line
`include "alcs_cfg.svh"

module alcs_line_config_status #(
	parameter int LINES = 16,
	parameter int SILO_DEPTH = 64,
	parameter logic [15:0] MOD_STOP_ANY_SPEED = 16'h0000
) (
	input wire logic sys_clk,
	input wire logic rst,
	input wire logic master_clear,
	input wire logic [2:0] reg_addr,
	input wire logic reg_wr,
	input wire logic reg_rd,
	input wire logic [15:0] reg_wdata,
	output logic [15:0] reg_rdata,
	output logic sys_irq,
	input wire alcs_pkg::alcs_tx_evt_t tx_evt,
	output logic tx_evt_ready,
	input wire alcs_pkg::alcs_rx_evt_t rx_evt,
	input wire logic [15:0] rx_lag,
	output logic [15:0] rx_hold,
	input wire logic [15:0] tx_serial,
	output logic [15:0] tx_line,
	input wire logic [15:0] rx_line,
	output logic [15:0] rx_to_card,
	input wire logic [15:0] remote_stop,
	output logic [15:0] tx_pause,
	output logic [63:0] line_speed,
	output logic [15:0] sel_line_divisor
);
	alcs_pkg::alcs_state_t st;
	alcs_pkg::alcs_state_t next_st;
	logic [7:0] silo [SILO_DEPTH];
	logic [15:0] sec_ram [256];
	logic [7:0] nsr_data;
	logic silo_load;
	logic silo_push;
	logic sar_wr;
	logic [7:0] sec_addr;
	logic [3:0] rx_code;

	// ----------------------------------------
	// Speed code to 16x oversample divisor
	// ----------------------------------------
	function automatic logic [15:0] speed_div(input logic [3:0] code);
		logic [31:0] baud_x10;
		baud_x10 = 32'h0;
		case (code)
			4'h0: baud_x10 = 32'd500;
			4'h1: baud_x10 = 32'd750;
			4'h2: baud_x10 = 32'd1100;
			4'h3: baud_x10 = 32'd1345;
			4'h4: baud_x10 = 32'd1500;
			4'h5: baud_x10 = 32'd3000;
			4'h6: baud_x10 = 32'd6000;
			4'h7: baud_x10 = 32'd12000;
			4'h8: baud_x10 = 32'd18000;
			4'h9: baud_x10 = 32'd20000;
			4'ha: baud_x10 = 32'd24000;
			4'hb: baud_x10 = 32'd36000;
			4'hc: baud_x10 = 32'd48000;
			4'hd: baud_x10 = 32'd72000;
			4'he: baud_x10 = 32'd96000;
			default: baud_x10 = 32'd384000;
		endcase
		speed_div = 16'((64'(`ALCS_CLK_HZ) * 64'd10) / (64'(baud_x10) * 64'(`ALCS_OVERSAMPLE)));
	endfunction

	// ----------------------------------------
	// Receive reason priority encoder
	// ----------------------------------------
	// Only defined codes can come out; memory faults outrank line errors,
	// overrun outranks framing, framing outranks parity.
	function automatic logic [3:0] rx_reason(input alcs_pkg::alcs_rx_evt_t e);
		logic [3:0] c;
		c = `ALCS_RX_SPECIAL;
		if (e.mpar_fetch)
			c = `ALCS_RX_MPAR_FETCH;
		else if (e.mpar_store)
			c = `ALCS_RX_MPAR_STORE;
		else if (e.nxm_fetch)
			c = `ALCS_RX_NXM_FETCH;
		else if (e.nxm_store)
			c = `ALCS_RX_NXM_STORE;
		else if (e.count_zero)
			c = `ALCS_RX_COUNT_ZERO;
		else if (e.overrun)
			c = `ALCS_RX_OVERRUN;
		else if (e.framing)
			c = `ALCS_RX_FRAMING;
		else if (e.parity_err)
			c = `ALCS_RX_PARITY;
		else if (e.bcc_done)
			c = `ALCS_RX_BCC_DONE;
		else if (e.count_warn)
			c = `ALCS_RX_COUNT_WARN;
		rx_reason = c;
	endfunction

	assign rx_code = rx_reason(rx_evt);
	assign sec_addr = {st.ss_reg, st.ss_line};
	assign sar_wr = reg_wr && reg_addr == `ALCS_IDX_SEC_ACCESS;
	assign silo_load = !st.nsr_valid && st.wptr != st.rptr;
	assign silo_push = tx_evt.valid && st.ready;

	// ----------------------------------------
	// Next state
	// ----------------------------------------
	always_comb
	begin
		logic [6:0] wp;
		logic [6:0] rp;
		logic [3:0] ln;
		logic stop_ok;
		wp = st.wptr;
		rp = st.rptr;
		ln = 4'h0;
		stop_ok = 1'b0;
		next_st = st;

		// Apply a pending strobe one cycle after the write that raised it
		if (st.strobe)
		begin
			unique case (st.sel)
				`ALCS_SEL_PRIMARY: next_st.primary[st.ss_line] = st.data;
				`ALCS_SEL_SPEED: next_st.speed[st.ss_line] = st.data;
				`ALCS_SEL_FORMAT: next_st.primary[st.ss_line] = st.primary[st.ss_line];
				`ALCS_SEL_LOOPBACK: next_st.loopback[st.ss_line] = st.data[`ALCS_LOOP_INTERNAL];
			endcase
			next_st.strobe = 1'b0;
		end

		if (reg_wr && reg_addr == `ALCS_IDX_LINE_CONTROL)
		begin
			next_st.sel = reg_wdata[`ALCS_LCW_SEL_LO +: 2];
			next_st.data = reg_wdata[`ALCS_LCW_DATA_LO +: 4];
			next_st.strobe = reg_wdata[`ALCS_LCW_STROBE];
		end
		if (reg_wr && reg_addr == `ALCS_IDX_SEC_SELECT)
		begin
			next_st.ss_line = reg_wdata[`ALCS_SS_LINE_LO +: 4];
			next_st.ss_reg = reg_wdata[`ALCS_SS_REG_LO +: 4];
		end

		// Transmit status silo; a pop and a load never share a cycle, so
		// a read cannot swallow an entry that is just arriving
		if (reg_rd && reg_addr == `ALCS_IDX_TX_STATUS && st.nsr_valid)
		begin
			next_st.nsr_valid = 1'b0;
			next_st.irq = 1'b0;
		end
		if (silo_load)
		begin
			rp = 7'(st.rptr + 7'h1);
			next_st.nsr_valid = 1'b1;
			next_st.irq = 1'b1;
		end
		if (silo_push)
			wp = 7'(st.wptr + 7'h1);
		next_st.wptr = wp;
		next_st.rptr = rp;
		// The word standing at the status output is one of the silo's entries,
		// so it counts against the depth; otherwise one push too many is taken
		next_st.ready = 7'(7'(wp - rp) + {6'h00, next_st.nsr_valid}) < 7'(SILO_DEPTH);

		if (rx_evt.valid)
		begin
			next_st.receive_event_word[15:12] = rx_code;
			next_st.receive_event_word[11:8] = rx_evt.line;
			next_st.receive_event_word[7:0] = rx_code == `ALCS_RX_BCC_DONE ? (rx_evt.bcc[15:8] | rx_evt.bcc[7:0])
				: rx_evt.char_data;
		end

		unique case (reg_addr)
			`ALCS_IDX_LINE_CONTROL: next_st.rdata = {st.strobe, st.data, st.sel, 9'h000};
			`ALCS_IDX_RX_EVENT: next_st.rdata = st.receive_event_word;
			`ALCS_IDX_TX_STATUS: next_st.rdata = {st.nsr_valid, 3'h0, nsr_data[7:4], 4'h0, nsr_data[3:0]};
			`ALCS_IDX_SYS_CONTROL: next_st.rdata = {st.irq, 15'h0000};
			`ALCS_IDX_SEC_SELECT: next_st.rdata = {4'h0, st.ss_reg, 4'h0, st.ss_line};
			`ALCS_IDX_SEC_ACCESS: next_st.rdata = sec_ram[sec_addr];
			default: next_st.rdata = 16'h0000;
		endcase
		if (!reg_rd)
			next_st.rdata = st.rdata;

		// Pin inputs: three stages, a change counts once stages two and three agree
		next_st.rx_sync = {st.rx_sync[1:0], rx_line};
		next_st.stop_sync = {st.stop_sync[1:0], remote_stop};
		for (int i = 0; i < LINES; i++)
		begin
			if (st.rx_sync[1][i] == st.rx_sync[2][i])
				next_st.rx_pin_f[i] = st.rx_sync[2][i];
			if (st.stop_sync[1][i] == st.stop_sync[2][i])
				next_st.stop_f[i] = st.stop_sync[2][i];
		end

		// Per-line data path and flow control
		for (int i = 0; i < LINES; i++)
		begin
			// Loop mode holds the outgoing lead at mark so the far end sees idle
			next_st.rx_to_card[i] = st.loopback[i] ? tx_serial[i] : st.rx_pin_f[i];
			next_st.tx_line[i] = st.loopback[i] ? 1'b1 : tx_serial[i];
			stop_ok = !st.loopback[i] && (st.speed[i] == `ALCS_SPEED_38400 || MOD_STOP_ANY_SPEED[i]);
			// Level is passed on at once; the card samples it at 15/16 of the stop bit
			next_st.pause[i] = stop_ok && st.stop_f[i];
			// One cycle of latency is far inside 10/16 of a bit even at 38400;
			// the hold is driven at every speed, so it is available at 38400
			next_st.hold[i] = rx_lag[i] && st.primary[i][`ALCS_PRI_RX_ENABLE] && !master_clear;
		end

		if (master_clear)
		begin
			next_st.hold = 16'h0000;
			next_st.primary = '0;
		end

		ln = st.ss_line;
		next_st.divisor = speed_div(st.speed[ln]);
	end

	// ----------------------------------------
	// State register
	// ----------------------------------------
	always_ff @(posedge sys_clk or posedge rst)
	begin
		if (rst)
		begin
			st <= '0;
			st.ready <= 1'b1;
			st.tx_line <= 16'hffff;
			st.rx_pin_f <= 16'hffff;
			st.rx_to_card <= 16'hffff;
			st.rx_sync <= '1;
		end
		else
			st <= next_st;
	end

	// ----------------------------------------
	// Storage without reset
	// ----------------------------------------
	// The status word's code and line survive reset; only its valid flag clears.
	always_ff @(posedge sys_clk)
	begin
		if (silo_push)
			silo[st.wptr[5:0]] <= {tx_evt.code, tx_evt.line};
		if (silo_load)
			nsr_data <= silo[st.rptr[5:0]];
		// Block check result takes the write port over a host write in the same cycle
		if (rx_evt.valid && rx_code == `ALCS_RX_BCC_DONE)
			sec_ram[{`ALCS_BCC_REG_CODE, rx_evt.line}] <= rx_evt.bcc;
		else if (sar_wr)
			sec_ram[sec_addr] <= reg_wdata;
	end

	// ----------------------------------------
	// Outputs
	// ----------------------------------------
	always_comb
	begin
		reg_rdata = st.rdata;
		sys_irq = st.irq;
		tx_evt_ready = st.ready;
		rx_hold = st.hold;
		tx_line = st.tx_line;
		rx_to_card = st.rx_to_card;
		tx_pause = st.pause;
		line_speed = st.speed;
		sel_line_divisor = st.divisor;
	end
endmodule

// >>> alcs_chk_asserts.sv
// Port checker for the line configuration and status block.
// Assumes it is bound to the top module, with default parameters.
module alcs_chk(
	input wire logic sys_clk,
	input wire logic rst,
	input wire logic master_clear,
	input wire logic [2:0] reg_addr,
	input wire logic reg_wr,
	input wire logic reg_rd,
	input wire logic [15:0] reg_wdata,
	input wire logic [15:0] reg_rdata,
	input wire logic sys_irq,
	input wire logic [15:0] rx_lag,
	input wire logic [15:0] rx_hold,
	input wire logic [15:0] tx_pause,
	input wire logic [63:0] line_speed
);
	logic [3:0] ss;
	// Shadow of the selected line, needed to find the loaded speed slice
	always_ff @(posedge sys_clk or posedge rst)
		if (rst)
			ss <= 4'h0;
		else if (reg_wr && reg_addr == 3'h4)
			ss <= reg_wdata[3:0];
	default clocking @(posedge sys_clk); endclocking
	default disable iff (rst);
	sequence s_spd_wr;
		reg_wr && reg_addr == 3'h0 && reg_wdata[15] && reg_wdata[10:9] == 2'h1;
	endsequence
	sequence s_stat_rd;
		reg_rd && reg_addr == 3'h2 && sys_irq;
	endsequence
	a_speed_load: assert property (s_spd_wr |-> ##2 line_speed[{ss, 2'h0} +: 4] == $past(reg_wdata[14:11], 2))
		else $error("speed code not loaded");
	a_rdata_hold: assert property (!reg_rd |=> $stable(reg_rdata))
		else $error("read data moved without a read");
	a_unmapped_zero: assert property (reg_rd && reg_addr[2:1] == 2'h3 |=> reg_rdata == 16'h0000)
		else $error("unmapped read not zero");
	a_pop_clears: assert property (s_stat_rd |=> !sys_irq)
		else $error("request not cleared by status read");
	a_pop_valid: assert property (s_stat_rd |=> reg_rdata[15])
		else $error("status word read without valid flag");
	a_mclr_hold: assert property (master_clear |=> rx_hold == 16'h0000)
		else $error("hold on after master clear");
	a_hold_cause: assert property ($rose(rx_hold[5]) |-> $past(rx_lag[5]))
		else $error("hold raised without lag");
	a_stop_slow: assert property ((line_speed[3:0] != 4'hf) [*6] |-> tx_pause[0] == 1'b0)
		else $error("remote stop obeyed below top speed");
endmodule

// >>> alcs_far_end.sv
// Line equipment on the far side of all sixteen lines.
// Assumes the bench raises stop_req when a remote stop is wanted.
module alcs_far_end(
	input wire logic sys_clk,
	input wire logic [15:0] rx_hold,
	input wire logic [15:0] stop_req,
	output logic [15:0] remote_stop,
	output logic [15:0] rx_line
);
	initial remote_stop = 16'h0000;
	initial rx_line = 16'h5555;
	always @(negedge sys_clk)
	begin
		remote_stop <= stop_req;
		// A held line's sender is restrained and idles at mark; others toggle
		rx_line <= rx_hold | ~rx_line;
	end
endmodule

// >>> alcs_line_config_status_tb_top.sv
// Self-checking bench for the line configuration and status block.
// Assumes default design parameters and the far-end model beside it.
module alcs_line_config_status_tb_top;
	timeunit 1ns;
	timeprecision 1ps;
	logic sys_clk = 1'b0;
	logic rst = 1'b1;
	logic master_clear = 1'b0;
	logic [2:0] reg_addr = 3'h0;
	logic reg_wr = 1'b0;
	logic reg_rd = 1'b0;
	logic rd_d = 1'b0;
	logic sys_irq, tx_evt_ready;
	logic [15:0] reg_wdata = 16'h0000, rx_lag = 16'h0000, tx_serial = 16'h0000, stop_req = 16'h0000;
	logic [15:0] reg_rdata, rx_hold, tx_line, rx_to_card, tx_pause, sel_line_divisor, remote_stop, rx_line;
	logic [63:0] line_speed;
	alcs_pkg::alcs_tx_evt_t tx_evt = '0;
	alcs_pkg::alcs_rx_evt_t rx_evt = '0;
	logic [15:0] exp_q[$], silo_q[$];
	int mismatches = 0, n_compared = 0, seed = 32'h07ed01d7;
	logic [3:0] cd [14] = '{4'hf, 4'he, 4'hd, 4'hc, 4'h5, 4'h8, 4'h4, 4'h3, 4'h2, 4'h1, 4'h0, 4'h3, 4'h2, 4'hc};
	alcs_line_config_status i_alcs_line_config_status (.sys_clk, .rst, .master_clear, .reg_addr, .reg_wr,
		.reg_rd, .reg_wdata, .reg_rdata, .sys_irq, .tx_evt, .tx_evt_ready, .rx_evt, .rx_lag, .rx_hold, .tx_serial,
		.tx_line, .rx_line, .rx_to_card, .remote_stop, .tx_pause, .line_speed, .sel_line_divisor);
	alcs_far_end i_alcs_far_end (.sys_clk, .rx_hold, .stop_req, .remote_stop, .rx_line);
	initial forever #12.5 sys_clk = ~sys_clk;
	// ----------------------------------------
	// Shared tasks
	// ----------------------------------------
	task automatic check(input logic [15:0] got, input logic [15:0] exp);
		n_compared++;
		if (got !== exp)
		begin
			mismatches++;
			$display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
		end
	endtask
	task automatic complete_run();
		if (mismatches == 0 && n_compared > 0)
			$display("*** PASS ***");
		else
			$display("*** FAIL ***");
		$finish;
	endtask
	task automatic cyc(input int n);
		repeat (n) @(negedge sys_clk);
	endtask
	task automatic acc(input logic [2:0] a, input logic w, input logic [15:0] d);
		@(negedge sys_clk);
		reg_addr = a;
		reg_wr = w;
		reg_rd = !w;
		reg_wdata = d;
		@(negedge sys_clk);
		reg_wr = 1'b0;
		reg_rd = 1'b0;
	endtask
	task automatic rd(input logic [2:0] a, input logic [15:0] e);
		exp_q.push_back(e);
		acc(a, 1'b0, 16'h0000);
	endtask
	// Read data is registered at the read edge, so it is settled by the next fall
	always @(posedge sys_clk) rd_d <= reg_rd;
	always @(negedge sys_clk)
		if (rd_d === 1'b1)
			check(reg_rdata, exp_q.pop_front());
	// ----------------------------------------
	// Main sequence
	// ----------------------------------------
	initial
	begin
		int i, k, ok;
		logic [15:0] d, b;
		logic [10:0] f;
		cyc(6);
		rst = 1'b0;
		for (i = 0; i < 16; i++)
		begin
			acc(3'h4, 1'b1, 16'(i));
			acc(3'h0, 1'b1, 16'h8200 | 16'(i << 11));
			cyc(2);
			check(16'(line_speed[i*4 +: 4]), 16'(i));
		end
		check(sel_line_divisor, 16'(40000000 / (16 * 38400)));
		acc(3'h4, 1'b1, 16'h0003);
		acc(3'h0, 1'b1, 16'hfa00);
		acc(3'h0, 1'b1, 16'h8e00);
		stop_req = 16'hffff;
		cyc(3);
		for (i = 0; i < 8; i++)
		begin
			d = 16'($random(seed));
			tx_serial = d;
			cyc(1);
			check(16'(rx_to_card[3]), 16'(d[3]));
			check(16'(tx_line[3]), 16'h0001);
			check(16'(tx_pause[3]) | 16'(tx_pause[0]), 16'h0000);
		end
		check(16'(tx_pause[15]), 16'h0001);
		acc(3'h0, 1'b1, 16'h8600);
		cyc(8);
		check(16'(tx_pause[3]), 16'h0001);
		stop_req = 16'h0000;
		cyc(8);
		check(tx_pause, 16'h0000);
		acc(3'h4, 1'b1, 16'h0005);
		acc(3'h0, 1'b1, 16'ha000);
		rx_lag = 16'h0020;
		cyc(4);
		check(rx_hold, 16'h0020);
		check(sel_line_divisor, 16'(40000000 / (16 * 300)));
		master_clear = 1'b1;
		cyc(1);
		master_clear = 1'b0;
		check(rx_hold, 16'h0000);
		acc(3'h0, 1'b1, 16'ha000);
		cyc(4);
		check(rx_hold, 16'h0020);
		acc(3'h0, 1'b1, 16'h8000);
		cyc(4);
		check(rx_hold, 16'h0000);
		rx_lag = 16'h0000;
		// Fill the silo until it refuses, then drain it in order
		k = 0;
		while (tx_evt_ready === 1'b1 && k < 80)
		begin
			d = 16'($random(seed)) & 16'h0f0f;
			tx_evt = {1'b1, d[11:8], d[3:0]};
			silo_q.push_back(d);
			k++;
			cyc(1);
		end
		tx_evt = '0;
		check(16'(k), 16'h0040);
		while (silo_q.size() > 0)
		begin
			ok = 0;
			while (sys_irq !== 1'b1 && ok < 20)
			begin
				ok++;
				cyc(1);
			end
			if (ok == 20)
			begin
				mismatches++;
				complete_run();
			end
			b = silo_q.pop_front();
			rd(3'h2, b | 16'h8000);
		end
		rd(3'h2, b);
		for (k = 0; k < 14; k++)
		begin
			f = (k < 11) ? 11'(1 << k) : (k == 11) ? 11'h280 : (k == 12) ? 11'h380 : 11'h028;
			d = 16'($random(seed));
			b = 16'($random(seed));
			rx_evt = '0;
			rx_evt.valid = 1'b1;
			rx_evt.char_data = d[7:0];
			rx_evt.line = d[11:8];
			rx_evt.bcc = b;
			{rx_evt.special, rx_evt.parity_err, rx_evt.overrun, rx_evt.framing, rx_evt.count_warn, rx_evt.count_zero,
				rx_evt.bcc_done, rx_evt.nxm_store, rx_evt.nxm_fetch, rx_evt.mpar_store, rx_evt.mpar_fetch} = f;
			cyc(1);
			rx_evt.valid = 1'b0;
			rd(3'h1, {cd[k], d[11:8], (k == 4) ? (b[15:8] | b[7:0]) : d[7:0]});
			if (k == 4)
			begin
				acc(3'h4, 1'b1, {8'h0b, 4'h0, d[11:8]});
				rd(3'h5, b);
			end
		end
		d = 16'($random(seed));
		b = ~d;
		acc(3'h4, 1'b1, 16'h0709);
		rd(3'h4, 16'h0709);
		acc(3'h5, 1'b1, d);
		acc(3'h4, 1'b1, 16'h0f00);
		acc(3'h5, 1'b1, b);
		acc(3'h4, 1'b1, 16'h0709);
		rd(3'h5, d);
		acc(3'h4, 1'b1, 16'h0f00);
		rd(3'h5, b);
		rd(3'h6, 16'h0000);
		acc(3'h7, 1'b1, 16'hffff);
		rd(3'h7, 16'h0000);
		// Reset keeps the last status word but drops its valid flag
		tx_evt = {1'b1, 4'h3, 4'ha};
		cyc(1);
		tx_evt = '0;
		cyc(6);
		rst = 1'b1;
		cyc(2);
		rst = 1'b0;
		rd(3'h2, 16'h030a);
		cyc(2);
		complete_run();
	end
endmodule
bind alcs_line_config_status alcs_chk i_alcs_chk (.sys_clk, .rst, .master_clear, .reg_addr, .reg_wr, .reg_rd,
	.reg_wdata, .reg_rdata, .sys_irq, .rx_lag, .rx_hold, .tx_pause, .line_speed);
